// ==== logic/rx_flow_ctrl_csr.sv ====
/*
  receive drop counter, indirect mac register port and automatic flow control
  for one ethernet controller. the host reaches four words over a simple
  synchronous register port; the mac register space, rx fifo and transmitter
  sit behind the user-side ports.
  assumes single-cycle host strobes synchronous to CLK, a byte count on
  RX_FIFO_FILL, and one MAC_DONE pulse per MAC_REQ, no earlier than the
  cycle after it; the transmitter enable and duplex are slow levels that
  do not toggle inside a frame.
*/
`timescale 1ns/1ns
`include "rx_flow_ctrl_csr_regs.svh"

module rx_flow_ctrl_csr #(
  parameter int FILL_W = 14
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // host register port
  input wire logic [7:0] ADDR,
  input wire logic RD,
  input wire logic WR,
  input wire logic [31:0] WDATA,
  output logic [31:0] RDATA,
  // drop counter
  input wire logic FRAME_DROPPED,
  output logic DROP_MIDPOINT_EVENT,
  // mac register space
  output logic MAC_REQ,
  output logic MAC_READ_NOT_WRITE,
  output logic [7:0] MAC_ADDR,
  output logic [31:0] MAC_WDATA,
  input wire logic MAC_DONE,
  input wire logic [31:0] MAC_RDATA,
  // receive side and link state
  input wire logic [FILL_W-1:0] RX_FIFO_FILL,
  input wire logic FRAME_START,
  input wire logic FRAME_MULTICAST,
  input wire logic FRAME_BROADCAST,
  input wire logic FRAME_OWN_ADDRESS,
  input wire logic FULL_DUPLEX,
  input wire logic SPEED_10M,
  input wire logic TX_ENABLED,
  // flow control actions
  output logic PAUSE_REQ,
  output logic PAUSE_ZERO_TIME,
  output logic BACK_PRESSURE
);
  logic [31:0] dropped_frame_tally;
  logic [31:0] mac_indirect_data;
  logic [31:0] auto_flow_control_config;
  logic access_pending;
  logic read_not_write;
  logic [7:0] target_reg;
  rx_flow_ctrl_pkg::ind_state_t ind_state;
  rx_flow_ctrl_pkg::fc_state_t fc_state;
  logic [7:0] flow_high_threshold;
  logic [7:0] flow_low_threshold;
  logic [3:0] jam_duration_code;
  logic trigger_on_multicast;
  logic trigger_on_broadcast;
  logic trigger_on_own_address;
  logic trigger_on_any_frame;
  logic [FILL_W-1:0] fill_units;
  logic above_high;
  logic below_low;
  logic frame_match;
  logic jam_start;
  logic jam_active;
  logic rd_drop;
  logic [2:0] trigger_sel;
  logic [2:0] frame_kind;
  logic [2:0] criterion_hit;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  // only a read of the drop counter has a side effect
  assign rd_drop = RD && (ADDR == `OFS_DROP_COUNT);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      unique case (ADDR)
        `OFS_DROP_COUNT: RDATA <= dropped_frame_tally;
        `OFS_IND_CMD: RDATA <= {access_pending, read_not_write, 22'h000000, target_reg};
        `OFS_IND_DATA: RDATA <= mac_indirect_data;
        `OFS_AUTO_FLOW_CONTROL_CONFIG: RDATA <= auto_flow_control_config & `AFC_WRITE_MASK;
        // unmapped offsets read zero
        default: RDATA <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // dropped frame counter
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      dropped_frame_tally <= `DROP_COUNT_RESET;
    end else if (rd_drop) begin
      // a drop in the read cycle counts in the fresh tally, so none is lost
      dropped_frame_tally <= FRAME_DROPPED ? 32'h00000001 : 32'h00000000;
    end else if (FRAME_DROPPED) begin
      // wraps past all ones; the midpoint event warns the host first
      dropped_frame_tally <= dropped_frame_tally + 32'h00000001;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      DROP_MIDPOINT_EVENT <= 1'b0;
    end else begin
      // a read-clear in the same cycle replaces the step, so no event then
      DROP_MIDPOINT_EVENT <= FRAME_DROPPED && !rd_drop &&
                             (dropped_frame_tally == (`DROP_MIDPOINT - 32'h00000001));
    end
  end

  // ----------------------------------------
  // indirect mac access
  // ----------------------------------------
  // command fields are refused while pending so the mac sees a steady address
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      read_not_write <= 1'b0;
      target_reg <= 8'h00;
    end else if (WR && (ADDR == `OFS_IND_CMD) && !access_pending) begin
      read_not_write <= WDATA[`CMD_RNW_BIT];
      target_reg <= WDATA[7:0];
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ind_state <= rx_flow_ctrl_pkg::IND_IDLE;
      access_pending <= 1'b0;
    end else begin
      unique case (ind_state)
        rx_flow_ctrl_pkg::IND_IDLE: begin
          // a start written while busy falls outside this state and is dropped
          if (WR && (ADDR == `OFS_IND_CMD) && WDATA[`CMD_PENDING_BIT]) begin
            access_pending <= 1'b1;
            ind_state <= rx_flow_ctrl_pkg::IND_ISSUE;
          end
        end
        rx_flow_ctrl_pkg::IND_ISSUE: begin
          ind_state <= rx_flow_ctrl_pkg::IND_WAIT;
        end
        rx_flow_ctrl_pkg::IND_WAIT: begin
          // the answer is only taken here, never in the request cycle
          if (MAC_DONE) begin
            access_pending <= 1'b0;
            ind_state <= rx_flow_ctrl_pkg::IND_IDLE;
          end
        end
      endcase
    end
  end

  // the mac answer lands here; host writes are ignored until the access is over
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      mac_indirect_data <= `IND_DATA_RESET;
    end else if (ind_state == rx_flow_ctrl_pkg::IND_WAIT && MAC_DONE && read_not_write) begin
      mac_indirect_data <= MAC_RDATA;
    end else if (WR && (ADDR == `OFS_IND_DATA) && !access_pending) begin
      mac_indirect_data <= WDATA;
    end
  end

  // ----------------------------------------
  // mac side outputs
  // ----------------------------------------
  assign MAC_REQ = (ind_state == rx_flow_ctrl_pkg::IND_ISSUE);
  assign MAC_READ_NOT_WRITE = read_not_write;
  assign MAC_ADDR = target_reg;
  assign MAC_WDATA = mac_indirect_data;

  // ----------------------------------------
  // flow control configuration
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      auto_flow_control_config <= `AUTO_FLOW_CONTROL_CONFIG_RESET;
    end else if (WR && (ADDR == `OFS_AUTO_FLOW_CONTROL_CONFIG)) begin
      // reserved bits never reach the register
      auto_flow_control_config <= WDATA & `AFC_WRITE_MASK;
    end
  end

  assign flow_high_threshold = auto_flow_control_config[`FLOW_HIGH_THRESHOLD_MSB:`FLOW_HIGH_THRESHOLD_LSB];
  assign flow_low_threshold = auto_flow_control_config[`FLOW_LOW_THRESHOLD_MSB:`FLOW_LOW_THRESHOLD_LSB];
  assign jam_duration_code = auto_flow_control_config[`AFC_DUR_MSB:`AFC_DUR_LSB];
  assign trigger_on_multicast = auto_flow_control_config[`AFC_MULT_BIT];
  assign trigger_on_broadcast = auto_flow_control_config[`AFC_BRD_BIT];
  assign trigger_on_own_address = auto_flow_control_config[`AFC_ADD_BIT];
  assign trigger_on_any_frame = auto_flow_control_config[`AFC_ANY_BIT];

  // ----------------------------------------
  // thresholds and frame matching
  // ----------------------------------------
  // fill is in bytes; thresholds count 64-byte units
  assign fill_units = RX_FIFO_FILL >> 6;
  assign above_high = (fill_units >= FILL_W'(flow_high_threshold));
  // lo under hi is left to software; nothing here enforces it
  assign below_low = (fill_units < FILL_W'(flow_low_threshold));

  // criteria and frame flags in one order: multicast, broadcast, own address
  assign trigger_sel = {trigger_on_multicast, trigger_on_broadcast, trigger_on_own_address};
  assign frame_kind = {FRAME_MULTICAST, FRAME_BROADCAST, FRAME_OWN_ADDRESS};

  for (genvar g = 0; g < 3; g++) begin : g_criterion
    assign criterion_hit[g] = trigger_sel[g] && frame_kind[g];
  end

  // the any-frame bit overrides the three criteria
  assign frame_match = trigger_on_any_frame || (criterion_hit != 3'b000);

  // ----------------------------------------
  // full duplex pause sequencing
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      fc_state <= rx_flow_ctrl_pkg::FC_CLEAR;
      PAUSE_REQ <= 1'b0;
      PAUSE_ZERO_TIME <= 1'b0;
    end else begin
      PAUSE_REQ <= 1'b0;
      // transmitter off holds the state, so a due pause goes out once it is back
      unique case (fc_state)
        rx_flow_ctrl_pkg::FC_CLEAR: begin
          if (FULL_DUPLEX && trigger_on_any_frame && TX_ENABLED && above_high) begin
            PAUSE_REQ <= 1'b1;
            PAUSE_ZERO_TIME <= 1'b0;
            fc_state <= rx_flow_ctrl_pkg::FC_PAUSED;
          end
        end
        // paused remembers a sent timed pause; only it arms the zero-time pause
        rx_flow_ctrl_pkg::FC_PAUSED: begin
          if (below_low && TX_ENABLED) begin
            PAUSE_REQ <= 1'b1;
            PAUSE_ZERO_TIME <= 1'b1;
            fc_state <= rx_flow_ctrl_pkg::FC_CLEAR;
          end
        end
        default: begin
          fc_state <= rx_flow_ctrl_pkg::FC_CLEAR;
        end
      endcase
    end
  end

  // ----------------------------------------
  // half duplex back pressure
  // ----------------------------------------
  // every matching frame start reloads the timer, so close frames stretch the jam
  assign jam_start = !FULL_DUPLEX && TX_ENABLED && above_high && FRAME_START && frame_match;

  // length follows the duration code and the link speed
  jam_timer u_jam_timer (
    .clk(CLK),
    .reset(RESET),
    .start(jam_start),
    .code(jam_duration_code),
    .speed_10m(SPEED_10M),
    .active(jam_active)
  );

  // ----------------------------------------
  // flow control outputs
  // ----------------------------------------
  assign BACK_PRESSURE = jam_active && TX_ENABLED && !FULL_DUPLEX;
endmodule

// ==== logic/rx_flow_ctrl_csr_regs.svh ====
/*
  register offsets, field positions, reset values and timing counts of the
  receive drop counter, indirect mac access and automatic flow control slice.
  assumes a 32-bit word register port with byte offsets.
*/
`ifndef RX_FLOW_CTRL_CSR_REGS_SVH
`define RX_FLOW_CTRL_CSR_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define OFS_DROP_COUNT 8'ha0
`define OFS_IND_CMD 8'ha4
`define OFS_IND_DATA 8'ha8
`define OFS_AUTO_FLOW_CONTROL_CONFIG 8'hac

// ----------------------------------------
// fields
// ----------------------------------------
`define CMD_PENDING_BIT 31
`define CMD_RNW_BIT 30
`define FLOW_HIGH_THRESHOLD_MSB 23
`define FLOW_HIGH_THRESHOLD_LSB 16
`define FLOW_LOW_THRESHOLD_MSB 15
`define FLOW_LOW_THRESHOLD_LSB 8
`define AFC_DUR_MSB 7
`define AFC_DUR_LSB 4
`define AFC_MULT_BIT 3
`define AFC_BRD_BIT 2
`define AFC_ADD_BIT 1
`define AFC_ANY_BIT 0
`define AFC_WRITE_MASK 32'h00ffffff
`define CMD_WRITE_MASK 32'h400000ff

// ----------------------------------------
// reset values
// ----------------------------------------
`define DROP_COUNT_RESET 32'h00000000
`define IND_DATA_RESET 32'h00000000
`define AUTO_FLOW_CONTROL_CONFIG_RESET 32'h00000000
`define DROP_MIDPOINT 32'h80000000

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 50
// jam length at 10 Mb/s exceeds the 100 Mb/s value by 2.2 us, in ns
`define JAM_EXTRA_10M_NS 2200
`define JAM_EXTRA_10M_CYCLES ((`JAM_EXTRA_10M_NS * `CLK_MHZ) / 1000)

`endif

// ==== logic/rx_flow_ctrl_pkg.sv ====
/*
  types shared by the flow control csr slice.
  assumes nothing of its surroundings.
*/
package rx_flow_ctrl_pkg;
  typedef enum logic [1:0] {
    IND_IDLE,
    IND_ISSUE,
    IND_WAIT
  } ind_state_t;

  typedef enum logic [1:0] {
    FC_CLEAR,
    FC_ARMED,
    FC_PAUSED
  } fc_state_t;
endpackage

// ==== logic/jam_timer.sv ====
/*
  back-pressure duration timer: loads a length from a 4-bit code and counts
  it down at the system clock.
  assumes a 50 MHz clock and a start pulse from the flow controller.
*/
`timescale 1ns/1ns
`include "rx_flow_ctrl_csr_regs.svh"

module jam_timer #(
  parameter int CNT_W = 15
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [3:0] code,
  input wire logic speed_10m,
  output logic active
);
  logic [CNT_W-1:0] remain;
  logic [CNT_W-1:0] length;

  // ----------------------------------------
  // duration table, 100 Mb/s values in microseconds
  // ----------------------------------------
  function automatic logic [9:0] dur_us(input logic [3:0] c);
    logic [9:0] v;
    v = 10'h000;
    unique case (c)
      4'h0: v = 10'h005;
      4'h1: v = 10'h00a;
      4'h2: v = 10'h00f;
      4'h3: v = 10'h019;
      default: v = 10'((int'(c) - 3) * 50);
    endcase
    return v;
  endfunction

  always_comb begin
    length = CNT_W'(int'(dur_us(code)) * `CLK_MHZ);
    if (speed_10m) begin
      length = CNT_W'(int'(length) + `JAM_EXTRA_10M_CYCLES);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      remain <= '0;
    end else if (start) begin
      remain <= length;
    end else if (remain != '0) begin
      remain <= remain - CNT_W'(1);
    end
  end

  assign active = (remain != '0);
endmodule

// ==== tb/mac_space_model.sv ====
/*
  behavioural model of the mac register space behind the indirect port.
  assumes one request pulse per access and a latency chosen by the bench.
*/
`timescale 1ns/1ns
module mac_space_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // access request
  input wire logic req,
  input wire logic rnw,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] lat,
  // answer
  output logic done,
  output logic [31:0] rdata
);
  logic [31:0] mem [256];
  logic [3:0] cnt;
  logic busy;
  logic [7:0] a;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt <= 4'h0;
      a <= 8'h00;
      rdata <= 32'h0;
    end else begin
      done <= 1'b0;
      // read data is not held outside the answer cycle
      rdata <= ~rdata;
      if (req) begin
        busy <= 1'b1;
        cnt <= lat;
        a <= addr;
        if (!rnw) mem[addr] <= wdata;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        done <= 1'b1;
        rdata <= mem[a];
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

// ==== tb/rx_flow_ctrl_csr_asserts.sv ====
/*
  concurrent checks on the csr slice ports.
  assumes it is bound to the design top and sees its ports only.
*/
`timescale 1ns/1ns
module rx_flow_ctrl_csr_asserts (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // host port
  input wire logic [7:0] ADDR,
  input wire logic RD,
  input wire logic WR,
  input wire logic [31:0] WDATA,
  input wire logic [31:0] RDATA,
  // user side
  input wire logic FRAME_DROPPED,
  input wire logic DROP_MIDPOINT_EVENT,
  input wire logic MAC_REQ,
  input wire logic MAC_READ_NOT_WRITE,
  input wire logic [7:0] MAC_ADDR,
  input wire logic FRAME_START,
  input wire logic FULL_DUPLEX,
  input wire logic TX_ENABLED,
  input wire logic PAUSE_REQ,
  input wire logic PAUSE_ZERO_TIME,
  input wire logic BACK_PRESSURE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  a_drop_event: assert property ($rose(DROP_MIDPOINT_EVENT) |-> $past(FRAME_DROPPED) ##1 !DROP_MIDPOINT_EVENT)
    else $error("midpoint event without a drop");
  a_start_cause: assert property (MAC_REQ |-> $past(WR) && $past(ADDR) == 8'ha4 && $past(WDATA) >= 32'h80000000)
    else $error("mac request without start write");
  a_start_fields: assert property (MAC_REQ |-> {24'h0, MAC_ADDR} == ($past(WDATA) & 32'hff) &&
    MAC_READ_NOT_WRITE == (($past(WDATA) & 32'h40000000) != 32'h0)) else $error("mac request fields wrong");
  a_req_pulse: assert property (MAC_REQ |=> !MAC_REQ) else $error("mac request longer than one cycle");
  a_rdata_hold: assert property (!$past(RD) |-> $stable(RDATA)) else $error("read data moved without read");
  a_pause_tx: assert property (PAUSE_REQ |-> $past(TX_ENABLED)) else $error("pause with transmitter off");
  a_pause_full: assert property (PAUSE_REQ && !PAUSE_ZERO_TIME |-> $past(FULL_DUPLEX))
    else $error("timed pause outside full duplex");
  a_pause_single: assert property (PAUSE_REQ && !PAUSE_ZERO_TIME |=> !(PAUSE_REQ && !PAUSE_ZERO_TIME))
    else $error("timed pause repeated");
  a_jam_cause: assert property ($rose(BACK_PRESSURE) |-> $past(FRAME_START) && !$past(FULL_DUPLEX) &&
    $past(TX_ENABLED)) else $error("back pressure without cause");
  a_jam_minimum: assert property ($rose(BACK_PRESSURE) |-> BACK_PRESSURE[*8]) else $error("back pressure too short");
  cover property (MAC_REQ && MAC_READ_NOT_WRITE);
  cover property (PAUSE_REQ && PAUSE_ZERO_TIME);
  cover property ($rose(BACK_PRESSURE));
  cover property (MAC_REQ && !MAC_READ_NOT_WRITE);
endmodule

bind rx_flow_ctrl_csr rx_flow_ctrl_csr_asserts u_chk (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .RD(RD), .WR(WR),
  .WDATA(WDATA), .RDATA(RDATA), .FRAME_DROPPED(FRAME_DROPPED), .DROP_MIDPOINT_EVENT(DROP_MIDPOINT_EVENT),
  .MAC_REQ(MAC_REQ), .MAC_READ_NOT_WRITE(MAC_READ_NOT_WRITE), .MAC_ADDR(MAC_ADDR), .FRAME_START(FRAME_START),
  .FULL_DUPLEX(FULL_DUPLEX), .TX_ENABLED(TX_ENABLED), .PAUSE_REQ(PAUSE_REQ), .PAUSE_ZERO_TIME(PAUSE_ZERO_TIME),
  .BACK_PRESSURE(BACK_PRESSURE));

// ==== tb/tb.sv ====
/*
  self-checking bench for the flow control csr slice.
  assumes the mac space model and the bound checker are compiled first.
*/
`timescale 1ns/1ns
module tb;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic clk = 1'b0, reset = 1'b1, rd = 1'b0, wr = 1'b0, dropped = 1'b0, fstart = 1'b0;
  logic mc = 1'b0, bc = 1'b0, own = 1'b0, fdx = 1'b0, spd = 1'b0, tx_en = 1'b0, last_zero;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v, mac_wdata, mac_rdata;
  logic [13:0] fill = 14'h0;
  logic [3:0] lat = 4'h0;
  logic [7:0] mac_addr;
  logic mac_req, mac_rnw, mac_done, pause_req, pause_zero, bp, mid;
  int errors = 0, n_compared = 0, n_pause = 0, n_mid = 0, n;
  row_t rows [11] = '{'{1'b0, 8'ha0, 32'h0, 32'h0}, '{1'b0, 8'ha4, 32'h0, 32'h0}, '{1'b0, 8'ha8, 32'h0, 32'h0},
    '{1'b0, 8'hac, 32'h0, 32'h0}, '{1'b1, 8'hac, 32'hffffffff, 32'h00ffffff}, '{1'b1, 8'ha8, 32'ha5a5a5a5, 32'ha5a5a5a5},
    '{1'b1, 8'ha4, 32'h7fffff00, 32'h40000000}, '{1'b1, 8'ha4, 32'h000000ff, 32'h000000ff},
    '{1'b1, 8'ha0, 32'hffffffff, 32'h0}, '{1'b0, 8'hb0, 32'h0, 32'h0}, '{1'b1, 8'hac, 32'h0, 32'h0}};

  always #10 clk = ~clk;
  always @(posedge clk) if (!reset && mid !== 1'b0) n_mid <= n_mid + 1;
  always @(posedge clk) if (pause_req === 1'b1) begin
    n_pause <= n_pause + 1;
    last_zero <= pause_zero;
  end

  rx_flow_ctrl_csr DUT (.CLK(clk), .RESET(reset), .ADDR(addr), .RD(rd), .WR(wr), .WDATA(wdata), .RDATA(rdata),
    .FRAME_DROPPED(dropped), .DROP_MIDPOINT_EVENT(mid), .MAC_REQ(mac_req), .MAC_READ_NOT_WRITE(mac_rnw),
    .MAC_ADDR(mac_addr), .MAC_WDATA(mac_wdata), .MAC_DONE(mac_done), .MAC_RDATA(mac_rdata), .RX_FIFO_FILL(fill),
    .FRAME_START(fstart), .FRAME_MULTICAST(mc), .FRAME_BROADCAST(bc), .FRAME_OWN_ADDRESS(own), .FULL_DUPLEX(fdx),
    .SPEED_10M(spd), .TX_ENABLED(tx_en), .PAUSE_REQ(pause_req), .PAUSE_ZERO_TIME(pause_zero), .BACK_PRESSURE(bp));
  mac_space_model mac (.clk(clk), .reset(reset), .req(mac_req), .rnw(mac_rnw), .addr(mac_addr), .wdata(mac_wdata),
    .lat(lat), .done(mac_done), .rdata(mac_rdata));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk); addr = a; wdata = d; wr = 1'b1;
    @(negedge clk); wr = 1'b0;
  endtask
  task rreg(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk); addr = a; rd = 1'b1;
    @(negedge clk); rd = 1'b0; d = rdata;
  endtask
  task poll();
    for (int k = 0; k < 40; k++) begin
      rreg(8'ha4, v);
      if (v[31] === 1'b0) return;
    end
    errors++;
  endtask
  task jam(input logic [2:0] f, output int cnt);
    @(negedge clk); {mc, bc, own} = f; fstart = 1'b1;
    @(negedge clk); fstart = 1'b0; cnt = 0;
    while (bp === 1'b1 && cnt < 40000) begin
      cnt++;
      @(negedge clk);
    end
    repeat (2) @(negedge clk);
  endtask
  task settle();
    repeat (6) @(negedge clk);
  endtask
  task end_sim();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    reset = 1'b0;
    foreach (rows[r]) begin
      if (rows[r].w) wreg(rows[r].a, rows[r].d);
      rreg(rows[r].a, v);
      check(v, rows[r].e);
    end
    @(negedge clk); dropped = 1'b1;
    repeat (3) @(negedge clk);
    dropped = 1'b0;
    rreg(8'ha0, v); check(v, 32'h3);
    @(negedge clk); addr = 8'ha0; rd = 1'b1; dropped = 1'b1;
    @(negedge clk); rd = 1'b0; dropped = 1'b0; check(rdata, 32'h0);
    rreg(8'ha0, v); check(v, 32'h1);
    check(32'(n_mid), 32'h0);
    wreg(8'ha8, 32'h12345678);
    wreg(8'ha4, 32'h80000034);
    poll();
    check(mac.mem[8'h34], 32'h12345678);
    lat = 4'h9;
    wreg(8'ha4, 32'hc0000034);
    rreg(8'ha4, v); check(v, 32'hc0000034);
    wreg(8'ha4, 32'h80000077);
    wreg(8'ha8, 32'h0);
    poll(); check(v, 32'h40000034);
    rreg(8'ha8, v); check(v, 32'h12345678);
    wreg(8'hac, 32'h00020101);
    fdx = 1'b1; tx_en = 1'b1; fill = 14'd127; settle(); check(32'(n_pause), 32'h0);
    fill = 14'd128; repeat (2) settle(); check(32'(n_pause), 32'h1);
    check({31'h0, last_zero}, 32'h0);
    fill = 14'd64; settle(); check(32'(n_pause), 32'h1);
    fill = 14'd63; settle(); check(32'(n_pause), 32'h2);
    check({31'h0, last_zero}, 32'h1);
    tx_en = 1'b0; fill = 14'd128; settle(); check(32'(n_pause), 32'h2);
    tx_en = 1'b1; fdx = 1'b0;
    for (int i = 0; i < 3; i++) begin
      wreg(8'hac, 32'h00020000 | (32'h8 >> i));
      jam(3'b100 >> i, n); check(32'(n), 32'd250);
      jam(3'b100 >> ((i + 1) % 3), n); check(32'(n), 32'h0);
    end
    wreg(8'hac, 32'h00020001);
    jam(3'b000, n);
    check(32'(n), 32'd250);
    wreg(8'hac, 32'h000200f8); spd = 1'b1;
    jam(3'b100, n); check(32'(n), 32'd30000 + 32'd110);
    fdx = 1'b1; jam(3'b100, n); check(32'(n), 32'h0);
    fdx = 1'b0; tx_en = 1'b0; jam(3'b100, n); check(32'(n), 32'h0);
    @(negedge clk); reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    rreg(8'ha8, v); check(v, 32'h0);
    rreg(8'hac, v); check(v, 32'h0);
    end_sim();
  end

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule
